// ===== hw/chgc_pkg.sv
// Constants, register layouts and state codes of the charger mode and cycle control.
// Assumes a single 250 MHz clock and an APB master with 32-bit data.
package chgc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ          = 250_000_000;
	localparam longint unsigned WDT_BASE_S      = 40;
	localparam longint unsigned WDT_BASE_CYC    = WDT_BASE_S * CLK_HZ;
	localparam longint unsigned BOOST_DELAY_MS  = 30;
	localparam longint unsigned BOOST_DELAY_CYC = BOOST_DELAY_MS * CLK_HZ / 1000;
	localparam longint unsigned IRQ_PULSE_NS    = 1000;
	localparam logic [15:0]     IRQ_PULSE_CYC   = 16'(IRQ_PULSE_NS * CLK_HZ / 1_000_000_000);
	localparam longint unsigned BLINK_MS        = 500;
	localparam longint unsigned BLINK_CYC       = BLINK_MS * CLK_HZ / 1000;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL0  = 8'h00;
	localparam logic [7:0] OFF_CTRL1  = 8'h04;
	localparam logic [7:0] OFF_CTRL2  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [18:0] rsv;
		logic        source_detect_request;
		logic        light_load_skip_disable;
		logic [4:0]  input_current_limit;
		logic [1:0]  battery_track_offset;
		logic [3:0]  input_voltage_limit;
	} chgc_ctrl0_t;

	typedef struct packed {
		logic [19:0] rsv;
		logic        battery_switch_force_off;
		logic        battery_switch_delay;
		logic        battery_switch_reset_enable;
		logic [1:0]  status_pin_function;
		logic        recharge_offset_select;
		logic [1:0]  watchdog_period;
		logic        watchdog_kick;
		logic        boost_current_select;
		logic        boost_enable_bit;
		logic        charge_enable_bit;
	} chgc_ctrl1_t;

	typedef struct packed {
		logic [10:0] rsv;
		logic [4:0]  charge_voltage_target;
		logic        safety_timer_6h;
		logic        jeita_profile;
		logic [3:0]  term_current;
		logic [3:0]  precharge_current;
		logic [5:0]  fast_charge_current;
	} chgc_ctrl2_t;

	typedef struct packed {
		logic [22:0] rsv;
		logic        skip_allowed;
		logic        boost_active;
		logic        host_mode;
		logic        watchdog_expired;
		logic [2:0]  source_type_status;
		logic [1:0]  charge_phase_status;
	} chgc_status_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam chgc_ctrl0_t CTRL0_RST = '{rsv: '0, source_detect_request: 1'b0,
		light_load_skip_disable: 1'b0, input_current_limit: 5'h04,
		battery_track_offset: 2'h0, input_voltage_limit: 4'h6};
	localparam chgc_ctrl1_t CTRL1_RST = '{rsv: '0, battery_switch_force_off: 1'b0,
		battery_switch_delay: 1'b0, battery_switch_reset_enable: 1'b1,
		status_pin_function: 2'h0, recharge_offset_select: 1'b0, watchdog_period: 2'h1,
		watchdog_kick: 1'b0, boost_current_select: 1'b1, boost_enable_bit: 1'b0,
		charge_enable_bit: 1'b1};
	localparam chgc_ctrl2_t CTRL2_RST = '{rsv: '0, charge_voltage_target: 5'h0b,
		safety_timer_6h: 1'b1, jeita_profile: 1'b1, term_current: 4'h2,
		precharge_current: 4'h2, fast_charge_current: 6'h22};

	// ----------------------------------------------------------------
	// Codes and scales
	// ----------------------------------------------------------------
	localparam logic [4:0]  ICL_SEL_HIGH = 5'h04;
	localparam logic [4:0]  ICL_SEL_LOW  = 5'h17;
	localparam logic [4:0]  ICL_LOW_SYS  = 5'h01;
	localparam logic [2:0]  SRC_NONE     = 3'h0;
	localparam logic [2:0]  SRC_USB      = 3'h1;
	localparam logic [2:0]  SRC_ADAPTER  = 3'h2;
	localparam logic [2:0]  SRC_BOOST    = 3'h7;
	localparam logic [1:0]  PHASE_OFF    = 2'h0;
	localparam logic [1:0]  PHASE_PRE    = 2'h1;
	localparam logic [1:0]  PHASE_FAST   = 2'h2;
	localparam logic [1:0]  PHASE_DONE   = 2'h3;
	localparam logic [1:0]  STAT_PIN_OFF = 2'h3;
	localparam logic [1:0]  WDT_OFF      = 2'h0;
	localparam logic [12:0] IVL_BASE_MV  = 13'h0f3c;
	localparam logic [12:0] IVL_STEP_MV  = 13'h0064;
	localparam logic [12:0] TRK_BASE_MV  = 13'h0096;
	localparam logic [12:0] TRK_STEP_MV  = 13'h0032;
	localparam logic [12:0] CVT_BASE_MV  = 13'h0f10;
	localparam logic [12:0] CVT_STEP_MV  = 13'h0020;
	localparam logic [12:0] RECHG_LO_MV  = 13'h0064;
	localparam logic [12:0] RECHG_HI_MV  = 13'h00c8;
	localparam logic [12:0] SHORT_MV     = 13'h0898;
	localparam logic [12:0] PRE_MV       = 13'h0bb8;
	localparam logic [11:0] SHORT_MA     = 12'h050;
	localparam logic [11:0] CUR_STEP_MA  = 12'h03c;

	typedef enum logic [2:0] {
		CS_IDLE   = 3'b001,
		CS_CHARGE = 3'b010,
		CS_DONE   = 3'b100
	} chgc_state_t;

endpackage : chgc_pkg

// ===== hw/chgc_pulse.sv
// Fixed-length active-low pulse generator for the interrupt pin.
// Assumes trigger is a one-cycle pulse synchronous to clock.
`timescale 1ns/100ps
module chgc_pulse
	import chgc_pkg::*;
(
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic trigger,
	output logic      pulse_n_ff
);

	typedef struct packed {
		logic        pulse_n;
		logic [15:0] cnt;
	} chgc_pst_t;

	chgc_pst_t st_ff;
	chgc_pst_t nxt_st;

	// A trigger during a running pulse is absorbed, so the pin never stays low.
	always_comb begin
		nxt_st = st_ff;
		if (!st_ff.pulse_n) begin
			nxt_st.cnt = st_ff.cnt - 16'h0001;
			if (st_ff.cnt == 16'h0001) begin
				nxt_st.pulse_n = 1'b1; // RULE25
			end
		end else if (trigger) begin
			nxt_st.pulse_n = 1'b0;
			nxt_st.cnt     = IRQ_PULSE_CYC;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_ff <= '{pulse_n: 1'b1, cnt: 16'h0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pulse_n_ff = st_ff.pulse_n;

	chk_pulse_len: assert property (@(posedge clock) disable iff (!reset_n) // RULE25
		$fell(st_ff.pulse_n) |-> !st_ff.pulse_n [*8] ##[1:300] st_ff.pulse_n)
		else $error("interrupt pulse length wrong");

endmodule : chgc_pulse

// ===== hw/chgc_top.sv
// Charger mode and cycle control: APB registers, watchdog, boost entry and charge cycle.
// Assumes analog comparator flags and the battery voltage code are synchronous to clock.
//
// Overview of operation
// RULE1: Input voltage limit 3.9V to 5.4V, default 4.5V.
// RULE2: Tracking picks larger of limit and battery plus offset.
// RULE3: Rail below 2.2V caps input current at 200mA.
// RULE4: Pulse skipping only when disabled or battery low.
// RULE5: Auto detection sets 500mA or 2400mA from select pin.
// RULE6: Boost waits 30ms plus battery, sleep, thermistor conditions.
// RULE7: One bit selects boost limit 0.5A or 1.2A.
// RULE8: Boost mode reports source type 111.
// RULE9: Reset gives default mode, expired flag set.
// RULE10: Kick write enters host mode, clears expired.
// RULE11: Period code 00 disables the watchdog.
// RULE12: Each kick restarts the watchdog count.
// RULE13: Expiry returns default mode, keeps limits and switch bits.
// RULE14: Charging needs enable bit set and pin low.
// RULE15: Defaults 4.208V, 2.04A, 180mA, JEITA, six hours.
// RULE16: Cycle starts only when every start condition holds.
// RULE17: Recharge below target minus offset, or enable toggle.
// RULE18: Terminate on voltage and current, not in regulation.
// RULE19: Status pin low charging, blinking fault, released otherwise; code releases it on a fault in CS_DONE.
// RULE20: Phase codes 00/01/10/11; completion pulses interrupt.
// RULE21: Current chosen by battery voltage bands.
// RULE22: Regulation blocks termination, halves safety timer rate.
// RULE23: Period 01 gives a 40 second watchdog.
// RULE24: Host requests source detection in host mode.
// RULE25: Interrupt is one fixed-length low pulse per event.
// RULE26: Phase re-evaluated continuously without restarting cycle.
`timescale 1ns/100ps
module chgc_top
	import chgc_pkg::*;
#(
	parameter logic [39:0] WDT_CYCLES   = 40'(WDT_BASE_CYC),
	parameter logic [31:0] BOOST_CYCLES = 32'(BOOST_DELAY_CYC),
	parameter logic [31:0] BLINK_CYCLES = 32'(BLINK_CYC)
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        source_select_pin,
	input  wire logic        charge_enable_pin_n,
	input  wire logic [12:0] vbat_mv,
	input  wire logic        sys_below_2v2,
	input  wire logic        vbat_below_sys_min,
	input  wire logic        converter_ready,
	input  wire logic        thermistor_input_ok,
	input  wire logic        boost_thermistor_ok,
	input  wire logic        boost_min_battery_ok,
	input  wire logic        input_in_sleep,
	input  wire logic        safety_timer_fault,
	input  wire logic        ibat_below_term,
	input  wire logic        thermal_regulation,
	input  wire logic        power_management,
	output logic [12:0]      eff_input_voltage_mv,
	output logic [4:0]       input_current_cap,
	output logic [11:0]      charge_current_ma,
	output logic             boost_mode,
	output logic             boost_limit_high,
	output logic             skip_allowed,
	output logic             safety_half_rate,
	output logic             status_pin_o,
	output logic             status_pin_oe,
	output logic             interrupt_pin_n
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [12:0] ivl_mv(input logic [3:0] code);
		ivl_mv = 13'(IVL_BASE_MV + IVL_STEP_MV * 13'(code));
	endfunction : ivl_mv

	function automatic logic [12:0] track_mv(input logic [1:0] code);
		track_mv = (code == 2'h0) ? 13'h0000 : 13'(TRK_BASE_MV + TRK_STEP_MV * 13'(code));
	endfunction : track_mv

	function automatic logic [11:0] step_ma(input logic [5:0] code);
		step_ma = 12'(CUR_STEP_MA * 12'(code));
	endfunction : step_ma

	function automatic logic [39:0] wdt_limit(input logic [1:0] period);
		case (period)
			2'h1:    wdt_limit = WDT_CYCLES;
			2'h2:    wdt_limit = 40'(WDT_CYCLES << 1);
			default: wdt_limit = 40'(WDT_CYCLES << 2);
		endcase
	endfunction : wdt_limit

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		chgc_ctrl0_t c0;
		chgc_ctrl1_t c1;
		chgc_ctrl2_t c2;
		chgc_state_t state;
		logic        host;
		logic        wdt_exp;
		logic [2:0]  src_det;
		logic [39:0] wdt_cnt;
		logic [31:0] boost_cnt;
		logic [31:0] blink_cnt;
		logic        blink;
		logic        boost_on;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [12:0] eff_vlim;
		logic [4:0]  icap;
		logic [11:0] chg_ma;
		logic        skip_ok;
		logic        half_rate;
		logic        stat_oe;
		logic        done_evt;
	} chgc_st_t;

	chgc_st_t     st_ff;
	chgc_st_t     nxt_st;
	chgc_status_t status;
	logic         access;
	logic         chg_enabled;
	logic         can_start;
	logic         terminate;
	logic         fault;
	logic [12:0]  target_mv;
	logic [12:0]  rechg_mv;
	logic [12:0]  trk_sum;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st       = st_ff;
		access       = psel && penable && st_ff.pready;
		chg_enabled  = st_ff.c1.charge_enable_bit && !charge_enable_pin_n; // RULE14
		target_mv    = 13'(CVT_BASE_MV + CVT_STEP_MV * 13'(st_ff.c2.charge_voltage_target));
		rechg_mv     = target_mv - (st_ff.c1.recharge_offset_select ? RECHG_HI_MV : RECHG_LO_MV);
		can_start    = converter_ready && thermistor_input_ok && !safety_timer_fault // RULE16
			&& !st_ff.c1.battery_switch_force_off && chg_enabled
			&& (st_ff.c2.fast_charge_current != 6'h00) && (vbat_mv < target_mv);
		terminate    = (vbat_mv > rechg_mv) && ibat_below_term // RULE18
			&& !thermal_regulation && !power_management; // RULE22
		fault        = chg_enabled && (safety_timer_fault || !thermistor_input_ok);
		trk_sum      = 13'(vbat_mv + track_mv(st_ff.c0.battery_track_offset));

		status                     = '0;
		status.skip_allowed        = st_ff.skip_ok;
		status.boost_active        = st_ff.boost_on;
		status.host_mode           = st_ff.host;
		status.watchdog_expired    = st_ff.wdt_exp;
		status.source_type_status  = st_ff.boost_on ? SRC_BOOST : st_ff.src_det; // RULE8
		case (st_ff.state)
			CS_CHARGE: status.charge_phase_status = (vbat_mv < PRE_MV) ? PHASE_PRE : PHASE_FAST;
			CS_DONE:   status.charge_phase_status = PHASE_DONE; // RULE20
			default:   status.charge_phase_status = PHASE_OFF;
		endcase

		// Self-clearing bits drop first so a same-cycle write still lands.
		nxt_st.c1.watchdog_kick = 1'b0;
		nxt_st.done_evt         = 1'b0;

		// Source detection: continuous in default mode, on request in host mode.
		if (!st_ff.host || st_ff.c0.source_detect_request) begin // RULE9 RULE24
			nxt_st.c0.input_current_limit = source_select_pin ? ICL_SEL_HIGH : ICL_SEL_LOW; // RULE5
			nxt_st.src_det                = source_select_pin ? SRC_USB : SRC_ADAPTER;
			nxt_st.c0.source_detect_request = 1'b0;
		end

		// Watchdog counts only in host mode with a nonzero period.
		if (st_ff.host && st_ff.c1.watchdog_period != WDT_OFF) begin // RULE11
			nxt_st.wdt_cnt = st_ff.wdt_cnt + 40'h1; // RULE23
			if (st_ff.wdt_cnt + 40'h1 >= wdt_limit(st_ff.c1.watchdog_period)) begin
				nxt_st.wdt_exp = 1'b1; // RULE13
				nxt_st.host    = 1'b0;
				nxt_st.wdt_cnt = '0;
				nxt_st.c0      = CTRL0_RST;
				nxt_st.c0.input_current_limit = st_ff.c0.input_current_limit;
				nxt_st.c0.input_voltage_limit = st_ff.c0.input_voltage_limit;
				nxt_st.c1      = CTRL1_RST;
				nxt_st.c1.battery_switch_force_off    = st_ff.c1.battery_switch_force_off;
				nxt_st.c1.battery_switch_delay        = st_ff.c1.battery_switch_delay;
				nxt_st.c1.battery_switch_reset_enable = st_ff.c1.battery_switch_reset_enable;
				nxt_st.c2      = CTRL2_RST;
			end
		end

		// APB: setup cycle latches read data, access cycle commits writes.
		nxt_st.pready = psel && !penable && !st_ff.pready;
		if (psel && !penable) begin
			nxt_st.pslverr = 1'b0;
			if (paddr == OFF_CTRL0) begin
				nxt_st.prdata = st_ff.c0;
			end else if (paddr == OFF_CTRL1) begin
				nxt_st.prdata = st_ff.c1;
			end else if (paddr == OFF_CTRL2) begin
				nxt_st.prdata = st_ff.c2;
			end else if (paddr == OFF_STATUS) begin
				nxt_st.prdata = status;
			end else begin
				nxt_st.prdata  = 32'h0000_0000;
				nxt_st.pslverr = 1'b1;
			end
		end
		if (access && pwrite && !st_ff.pslverr) begin
			if (paddr == OFF_CTRL0) begin
				nxt_st.c0     = pwdata;
				nxt_st.c0.rsv = '0;
			end else if (paddr == OFF_CTRL1) begin
				nxt_st.c1     = pwdata;
				nxt_st.c1.rsv = '0;
				if (pwdata[3]) begin
					nxt_st.host    = 1'b1; // RULE10
					nxt_st.wdt_cnt = '0; // RULE12
					nxt_st.c1.watchdog_kick = 1'b0;
					// A kick in the expiry cycle wins, so the flag clears as well.
					nxt_st.wdt_exp = 1'b0; // RULE10
				end
			end else if (paddr == OFF_CTRL2) begin
				nxt_st.c2     = pwdata;
				nxt_st.c2.rsv = '0;
			end
		end

		// Boost entry needs the enable held for the full delay.
		if (!st_ff.c1.boost_enable_bit) begin
			nxt_st.boost_cnt = '0;
		end else if (st_ff.boost_cnt < BOOST_CYCLES) begin
			nxt_st.boost_cnt = st_ff.boost_cnt + 32'h1;
		end
		nxt_st.boost_on = st_ff.c1.boost_enable_bit && (st_ff.boost_cnt >= BOOST_CYCLES) // RULE6
			&& boost_min_battery_ok && input_in_sleep && boost_thermistor_ok;

		// Charge cycle.
		case (st_ff.state)
			CS_IDLE: begin
				if (can_start) begin
					nxt_st.state = CS_CHARGE; // RULE16
				end
			end
			CS_CHARGE: begin
				if (!chg_enabled) begin
					nxt_st.state = CS_IDLE;
				end else if (terminate) begin
					nxt_st.state    = CS_DONE; // RULE18
					nxt_st.done_evt = 1'b1; // RULE20
				end
			end
			CS_DONE: begin
				if (!chg_enabled) begin
					nxt_st.state = CS_IDLE; // RULE17
				end else if (vbat_mv < rechg_mv && can_start) begin
					nxt_st.state = CS_CHARGE; // RULE17
				end
			end
			default: nxt_st.state = CS_IDLE;
		endcase

		// Current follows the voltage band on every cycle.
		if (st_ff.state != CS_CHARGE) begin
			nxt_st.chg_ma = 12'h000;
		end else if (vbat_mv < SHORT_MV) begin
			nxt_st.chg_ma = SHORT_MA; // RULE21
		end else if (vbat_mv < PRE_MV) begin
			nxt_st.chg_ma = step_ma(6'(st_ff.c2.precharge_current) + 6'h01); // RULE21
		end else begin
			nxt_st.chg_ma = step_ma(st_ff.c2.fast_charge_current); // RULE21 RULE26
		end

		nxt_st.eff_vlim = ivl_mv(st_ff.c0.input_voltage_limit); // RULE1
		if (st_ff.c0.battery_track_offset != 2'h0 && trk_sum > nxt_st.eff_vlim) begin
			nxt_st.eff_vlim = trk_sum; // RULE2
		end
		nxt_st.icap = st_ff.c0.input_current_limit;
		if (sys_below_2v2 && st_ff.c0.input_current_limit > ICL_LOW_SYS) begin
			nxt_st.icap = ICL_LOW_SYS; // RULE3
		end
		nxt_st.skip_ok   = !st_ff.c0.light_load_skip_disable // RULE4
			&& (!chg_enabled || vbat_below_sys_min);
		nxt_st.half_rate = thermal_regulation || power_management; // RULE22

		// Status pin blinks on a fault outside CS_DONE, else pulls low while charging.
		if (st_ff.blink_cnt + 32'h1 >= BLINK_CYCLES) begin
			nxt_st.blink_cnt = '0;
			nxt_st.blink     = !st_ff.blink;
		end else begin
			nxt_st.blink_cnt = st_ff.blink_cnt + 32'h1;
		end
		if (st_ff.c1.status_pin_function == STAT_PIN_OFF) begin
			nxt_st.stat_oe = 1'b0; // RULE19
		end else if (fault && st_ff.state != CS_DONE) begin
			nxt_st.stat_oe = st_ff.blink; // RULE19
		end else begin
			nxt_st.stat_oe = (st_ff.state == CS_CHARGE); // RULE19
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_ff         <= '0;
			st_ff.c0      <= CTRL0_RST;
			st_ff.c1      <= CTRL1_RST;
			st_ff.c2      <= CTRL2_RST; // RULE15
			st_ff.state   <= CS_IDLE;
			st_ff.wdt_exp <= 1'b1; // RULE9
			st_ff.src_det <= SRC_NONE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	chgc_pulse u_irq (
		.clock      (clock),
		.reset_n    (reset_n),
		.trigger    (st_ff.done_evt),
		.pulse_n_ff (interrupt_pin_n)
	);

	assign pready               = st_ff.pready;
	assign prdata               = st_ff.prdata;
	assign pslverr              = st_ff.pslverr;
	assign eff_input_voltage_mv = st_ff.eff_vlim;
	assign input_current_cap    = st_ff.icap;
	assign charge_current_ma    = st_ff.chg_ma;
	assign boost_mode           = st_ff.boost_on;
	assign boost_limit_high     = st_ff.c1.boost_current_select; // RULE7
	assign skip_allowed         = st_ff.skip_ok;
	assign safety_half_rate     = st_ff.half_rate;
	assign status_pin_o         = 1'b0;
	assign status_pin_oe        = st_ff.stat_oe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence kick_write;
		access && pwrite && paddr == OFF_CTRL1 && pwdata[3];
	endsequence

	sequence term_event;
		st_ff.state == CS_CHARGE && chg_enabled && terminate;
	endsequence

	chk_kick_host: assert property (kick_write |=> st_ff.host && !st_ff.wdt_exp) // RULE10
		else $error("kick did not enter host mode");
	chk_wdt_off_hold: assert property (st_ff.host && st_ff.c1.watchdog_period == WDT_OFF // RULE11
		&& !(access && pwrite && paddr == OFF_CTRL1) |=> st_ff.host)
		else $error("disabled watchdog left host mode");
	chk_done_irq: assert property (term_event |=> st_ff.state == CS_DONE // RULE20
		##1 !interrupt_pin_n)
		else $error("completion without interrupt pulse");
	chk_boost_src: assert property (st_ff.boost_on && psel && !penable && paddr == OFF_STATUS // RULE8
		|=> prdata[4:2] == SRC_BOOST)
		else $error("boost source type wrong");
	chk_boost_delay: assert property ($rose(st_ff.c1.boost_enable_bit) // RULE6
		|-> !st_ff.boost_on [*8])
		else $error("boost entered before delay");
	chk_icl_cap: assert property (sys_below_2v2 |=> input_current_cap <= ICL_LOW_SYS) // RULE3
		else $error("low rail cap missing");
	chk_start_guard: assert property (st_ff.state == CS_IDLE && !can_start // RULE16
		|=> st_ff.state == CS_IDLE)
		else $error("cycle started without conditions");
	chk_stat_released: assert property (st_ff.c1.status_pin_function == STAT_PIN_OFF // RULE19
		|=> !status_pin_oe)
		else $error("status pin driven while released");
	chk_no_term_reg: assert property (st_ff.state == CS_CHARGE // RULE22
		&& (thermal_regulation || power_management) |=> st_ff.state != CS_DONE)
		else $error("terminated during regulation");

endmodule : chgc_top

// ===== verif/chgc_host.sv
// APB host model that programs the charger registers.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/100ps
module chgc_host (
	input  wire logic        clock,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// A kick or detect request is simply a write of the bit.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = (n < 50) ? prdata : 32'hx;
		e = (n < 50) ? pslverr : 1'bx;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : xfer
endmodule : chgc_host

// ===== verif/chgc_top_tb.sv
// Self-checking bench of the charger control block.
// Assumes shortened watchdog, boost and blink counts.
`timescale 1ns/100ps
module chgc_top_tb;
	import chgc_pkg::*;
	logic clock, reset_n = 1'b0, source_select_pin = 1'b1, charge_enable_pin_n = 1'b1;
	logic sys_below_2v2 = 1'b0, vbat_below_sys_min = 1'b0, converter_ready = 1'b1;
	logic thermistor_input_ok = 1'b1, boost_thermistor_ok = 1'b1, boost_min_battery_ok = 1'b1;
	logic input_in_sleep = 1'b0, safety_timer_fault = 1'b0, ibat_below_term = 1'b0;
	logic thermal_regulation = 1'b0, power_management = 1'b0, e;
	logic [12:0] vbat_mv = 13'd3500;
	logic psel, penable, pwrite, pready, pslverr, boost_mode, boost_limit_high, skip_allowed;
	logic status_pin_oe, interrupt_pin_n, safety_half_rate, status_pin_o;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [12:0] eff_input_voltage_mv;
	logic [4:0] input_current_cap;
	logic [11:0] charge_current_ma;
	int n_errors = 0, n_tests = 0, i;
	chgc_top #(.WDT_CYCLES(40'd200), .BOOST_CYCLES(32'd20), .BLINK_CYCLES(32'd16)) dut_u (
		.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .source_select_pin, .charge_enable_pin_n, .vbat_mv, .sys_below_2v2,
		.vbat_below_sys_min, .converter_ready, .thermistor_input_ok, .boost_thermistor_ok,
		.boost_min_battery_ok, .input_in_sleep, .safety_timer_fault, .ibat_below_term,
		.thermal_regulation, .power_management, .eff_input_voltage_mv, .input_current_cap,
		.charge_current_ma, .boost_mode, .boost_limit_high, .skip_allowed,
		.safety_half_rate, .status_pin_o, .status_pin_oe, .interrupt_pin_n);
	chgc_host host_u (.clock, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, s, x);
		end
	endtask : chk
	// A transfer that never sees pready counts as a mismatch and ends the run.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(w, a, d, q, e);
		if (e === 1'bx) begin
			n_errors++;
			complete_run();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic complete_run;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk(eff_input_voltage_mv, 4500);
		chk(skip_allowed, 1);
		rd(OFF_CTRL0);
		chk(q, 32'h106);
		rd(OFF_CTRL1);
		chk(q, 32'h215);
		rd(OFF_CTRL2);
		chk(q, 32'hbc8a2);
		rd(OFF_STATUS);
		chk(q[6:2], 5'h09);
		rd(8'h10);
		chk(e, 1);
		source_select_pin <= 1'b0;
		repeat (3) @(posedge clock);
		chk(input_current_cap, ICL_SEL_LOW);
		sys_below_2v2 <= 1'b1;
		repeat (3) @(posedge clock);
		chk(input_current_cap, ICL_LOW_SYS);
		sys_below_2v2 <= 1'b0;
		source_select_pin <= 1'b1;
		vbat_mv <= 13'd4400;
		wr(OFF_CTRL0, 32'h136);
		repeat (2) @(posedge clock);
		chk(eff_input_voltage_mv, 4700);
		wr(OFF_CTRL0, 32'h10f);
		$display("limits done");
		wr(OFF_CTRL1, 32'h219);
		rd(OFF_STATUS);
		chk(q[6:5], 2'b10);
		chk(boost_limit_high, 0);
		source_select_pin <= 1'b0;
		repeat (3) @(posedge clock);
		chk(input_current_cap, ICL_SEL_HIGH);
		wr(OFF_CTRL0, 32'h110f);
		repeat (2) @(posedge clock);
		chk(input_current_cap, ICL_SEL_LOW);
		repeat (150) @(posedge clock);
		wr(OFF_CTRL1, 32'h219);
		repeat (150) @(posedge clock);
		rd(OFF_STATUS);
		chk(q[6:5], 2'b10);
		repeat (60) @(posedge clock);
		rd(OFF_STATUS);
		chk(q[6:5], 2'b01);
		rd(OFF_CTRL0);
		chk(q[3:0], 4'hf);
		rd(OFF_CTRL1);
		chk(q, 32'h215);
		wr(OFF_CTRL1, 32'h20d);
		repeat (300) @(posedge clock);
		rd(OFF_STATUS);
		chk(q[6:5], 2'b10);
		$display("watchdog done");
		source_select_pin <= 1'b1;
		vbat_mv <= 13'd3500;
		charge_enable_pin_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk(charge_current_ma, 2040);
		chk(status_pin_oe, 1);
		chk(status_pin_o, 0);
		rd(OFF_STATUS);
		chk(q[1:0], PHASE_FAST);
		vbat_mv <= 13'd2500;
		repeat (3) @(posedge clock);
		chk(charge_current_ma, 180);
		vbat_mv <= 13'd2000;
		repeat (3) @(posedge clock);
		chk(charge_current_ma, 80);
		charge_enable_pin_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk(charge_current_ma, 0);
		charge_enable_pin_n <= 1'b0;
		vbat_mv <= 13'd4150;
		ibat_below_term <= 1'b1;
		thermal_regulation <= 1'b1;
		repeat (8) @(posedge clock);
		chk(interrupt_pin_n, 1);
		chk(safety_half_rate, 1);
		thermal_regulation <= 1'b0;
		for (i = 0; i < 10 && interrupt_pin_n !== 1'b0; i++) @(posedge clock);
		chk(interrupt_pin_n, 0);
		rd(OFF_STATUS);
		chk(q[1:0], PHASE_DONE);
		chk(status_pin_oe, 0);
		repeat (240) @(posedge clock);
		chk(interrupt_pin_n, 0);
		repeat (10) @(posedge clock);
		chk(interrupt_pin_n, 1);
		ibat_below_term <= 1'b0;
		vbat_mv <= 13'd4000;
		repeat (4) @(posedge clock);
		chk(charge_current_ma, 2040);
		$display("charge done");
		input_in_sleep <= 1'b1;
		wr(OFF_CTRL1, 32'h207);
		repeat (10) @(posedge clock);
		chk(boost_mode, 0);
		repeat (20) @(posedge clock);
		chk(boost_mode, 1);
		rd(OFF_STATUS);
		chk(q[4:2], SRC_BOOST);
		$display("boost done");
		complete_run();
	end
endmodule : chgc_top_tb
